// ===== dv/tb_user_defined_compare_output.sv
module tb_user_defined_compare_output;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [15:0] m, s, d, l, h, v; logic x;} ucmp_row_s;
    logic         sys_clk = 1'b0;
    logic         rst_n   = 1'b0;
    logic         psel    = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite  = 1'b0;
    logic [7:0]   paddr   = 8'h0;
    logic [31:0]  pwdata  = 32'h0;
    logic [799:0] mon     = '0;
    logic [2:0]   tlog    = 3'h0;
    logic [31:0]  prdata, rd;
    logic         pready, pslverr, er;
    logic [2:0]   term_drive, contact;
    logic [1:0]   user_out;
    logic [15:0]  timer_preset;
    int           errors = 0;
    int           samples_checked = 0;
    int           n;
    ucmp_row_s rows [12] = '{'{16'ha, 16'h3, 16'h0, 16'h32, 16'h0, 16'h32, 1'b1},
        '{16'ha, 16'h3, 16'h5, 16'h32, 16'h0, 16'h34, 1'b0}, '{16'hb, 16'h31, 16'h0, 16'h7d0, 16'h0, 16'h7d0, 1'b1},
        '{16'hb, 16'h31, 16'h0, 16'h7d0, 16'h0, 16'h7cf, 1'b0}, '{16'hc, 16'h7, 16'h0, 16'h1388, 16'h0, 16'h1388, 1'b1},
        '{16'hc, 16'h7, 16'h0, 16'h1388, 16'h0, 16'h1389, 1'b0}, '{16'hd, 16'hd, 16'h0, 16'h12c, 16'h258, 16'h12c, 1'b0},
        '{16'hd, 16'hd, 16'h64, 16'h12c, 16'h258, 16'h258, 1'b1}, '{16'he, 16'h5, 16'h0, 16'h8, 16'h9, 16'h9, 1'b1},
        '{16'h4, 16'h5, 16'h0, 16'h8, 16'h9, 16'ha, 1'b1}, '{16'hb, 16'h32, 16'h0, 16'h1, 16'h0, 16'h7, 1'b0},
        '{16'h5, 16'h3, 16'h0, 16'h32, 16'h0, 16'h32, 1'b1}};
    logic [17:0] hs [6] = '{18'h100c8, 18'h2005a, 18'h20069, 18'h2006d, 18'h1006e, 18'h1005f};
    logic [18:0] ps [6] = '{19'h00000, 19'h10001, 19'h6006e, 19'h40066, 19'h02af8, 19'h7006f};

    always #50 sys_clk = ~sys_clk;

    ucmp_top #(.TICK_CYCLES(4)) ucmp_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .monitor_values(mon), .term_logic(tlog), .term_drive(term_drive), .user_out(user_out),
        .timer_preset(timer_preset));
    ucmp_term_model ucmp_term_model_i (.sys_clk(sys_clk), .term_drive(term_drive), .contact_closed(contact));

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [4:0] ix, input logic [31:0] d);
        int k = 0;
        @(posedge sys_clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {1'b0, ix, 2'b00};
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        check("pready", 32'(k < 20), 32'h1);
    endtask : apb

    // field order inside a channel block: source, method, dead zone, low, high
    task automatic cfg(input logic [4:0] b, input ucmp_row_s r);
        apb(1'b1, b, {16'h0, r.s});
        apb(1'b1, b + 5'h1, {16'h0, r.m});
        apb(1'b1, b + 5'h2, {16'h0, r.d});
        apb(1'b1, b + 5'h3, {16'h0, r.l});
        apb(1'b1, b + 5'h4, {16'h0, r.h});
    endtask : cfg

    task automatic summarize;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (5000) @(posedge sys_clk);
        errors++;
        summarize();
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        for (int i = 0; i < 20; i++) begin
            apb(1'b0, 5'(i), 32'h0);
            check("reset_value", rd, 32'h0);
            check("slverr", {31'h0, er}, {31'h0, i == 19});
        end
        apb(1'b1, 5'h12, 32'h1);
        check("status_write", {31'h0, er}, 32'h1);
        apb(1'b1, 5'hb, 32'hffff2710);
        apb(1'b0, 5'hb, 32'h0);
        check("timer_rd", rd, 32'h2710);
        check("timer_port", {16'h0, timer_preset}, 32'h2710);
        foreach (rows[i]) begin
            if (rows[i].s < 16'h32) begin
                mon[rows[i].s * 16 +: 16] <= rows[i].v;
            end
            cfg(5'h1, rows[i]);
            cfg(5'h6, rows[i]);
            repeat (2) @(posedge sys_clk);
            check("user_out", {30'h0, user_out}, {30'h0, {2{rows[i].x}}});
        end
        cfg(5'h1, '{16'hb, 16'h0, 16'ha, 16'h64, 16'h0, 16'h0, 1'b0});
        cfg(5'h6, '{16'hc, 16'h0, 16'ha, 16'h64, 16'h0, 16'h0, 1'b0});
        foreach (hs[k]) begin
            mon[15:0] <= hs[k][15:0];
            repeat (3) @(posedge sys_clk);
            check("hysteresis", {30'h0, user_out}, {30'h0, hs[k][17:16]});
        end
        foreach (ps[k]) begin
            apb(1'b1, 5'h0, {16'h0, ps[k][15:0]});
            for (int t = 0; t < 8; t++) begin
                tlog <= 3'(t);
                repeat (4) @(posedge sys_clk);
                check("term_drive", {29'h0, term_drive}, {29'h0, 3'(t) ^ ps[k][18:16]});
                check("contact", {29'h0, contact}, {29'h0, 3'(t) ^ ps[k][18:16]});
            end
        end
        apb(1'b1, 5'h0, 32'h0);
        tlog <= 3'h0;
        apb(1'b1, 5'hc, 32'h2);
        tlog <= 3'h1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (term_drive[0] !== 1'b1 && n < 30);
        check("connect_delay", 32'(n >= 5 && n <= 11), 32'h1);
        // second relay output (term_drive[1]): connect at once, then disconnect after one 0.1 s unit
        apb(1'b1, 5'h10, 32'h1);
        tlog <= 3'h3;
        repeat (4) @(posedge sys_clk);
        tlog <= 3'h1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (term_drive[1] !== 1'b0 && n < 30);
        check("disconnect_delay", 32'(n >= 4 && n <= 7), 32'h1);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        apb(1'b0, 5'hb, 32'h0);
        check("timer_after_reset", rd, 32'h0);
        summarize();
    end
endmodule : tb_user_defined_compare_output

// ===== dv/ucmp_term_model.sv
module ucmp_term_model (
    input  wire logic       sys_clk,        // clock
    input  wire logic [2:0] term_drive,     // coil drive
    output logic      [2:0] contact_closed  // contact to common
);
    timeunit 1ns;
    timeprecision 1ns;
    // contact lags the coil one cycle, so the bench sees a slow relay
    always_ff @(posedge sys_clk) begin
        contact_closed <= term_drive;
    end
endmodule : ucmp_term_model

// ===== dv/ucmp_top_sva.sv
`include "ucmp_defines.svh"

module ucmp_top_sva #(
    parameter int NUM_SRC     = 50,
    parameter int TICK_CYCLES = `UCMP_TICK_CYCLES
) (
    input wire logic                  sys_clk,        // clock
    input wire logic                  rst_n,          // reset
    input wire logic                  psel,           // select
    input wire logic                  penable,        // access
    input wire logic                  pwrite,         // direction
    input wire logic [7:0]            paddr,          // address
    input wire logic [31:0]           pwdata,         // wdata
    input wire logic [31:0]           prdata,         // rdata
    input wire logic                  pready,         // ready
    input wire logic                  pslverr,        // error
    input wire logic [NUM_SRC*16-1:0] monitor_values, // sources
    input wire logic [2:0]            term_logic,     // request
    input wire logic [2:0]            term_drive,     // drive
    input wire logic [1:0]            user_out,       // outputs
    input wire logic [15:0]           timer_preset    // timer
);
    timeunit 1ns;
    timeprecision 1ns;
    // design leaves reset two edges after rst_n; outputs settle after that
    logic [2:0] live_q;
    wire        armed = live_q == 3'h4;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            live_q <= 3'h0;
        end else if (!armed) begin
            live_q <= live_q + 3'h1;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n || !armed);
    wire [5:0] idx    = paddr[7:2];
    wire       acc_wr = psel && penable && pready && pwrite;

    ready_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("ready not in second access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_pair_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside ready");
    bad_access_a: assert property (pready && (idx > 6'h12 || (pwrite && idx == 6'h12)) |-> pslverr)
        else $error("bad access not refused");
    timer_write_a: assert property (acc_wr && idx == 6'h0b |=> timer_preset == $past(pwdata[15:0]))
        else $error("timer preset not stored");
    timer_hold_a: assert property (!(acc_wr && idx == 6'h0b) |=> $stable(timer_preset))
        else $error("timer preset changed unasked");
    user_hold_a: assert property ((!psel && $stable(monitor_values)) [*4] |=> $stable(user_out))
        else $error("user output moved with inputs still");
endmodule : ucmp_top_sva

bind ucmp_top ucmp_top_sva #(.NUM_SRC(NUM_SRC), .TICK_CYCLES(TICK_CYCLES)) ucmp_top_sva_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .monitor_values(monitor_values),
    .term_logic(term_logic), .term_drive(term_drive), .user_out(user_out), .timer_preset(timer_preset));

// ===== src/ucmp_defines.svh
`ifndef UCMP_DEFINES_SVH
`define UCMP_DEFINES_SVH

// register word indexes; byte address is index * 4
`define UCMP_IDX_POLARITY    5'h00
`define UCMP_IDX_CH1_BASE    5'h01
`define UCMP_IDX_CH2_BASE    5'h06
`define UCMP_IDX_TIMER       5'h0b
`define UCMP_IDX_CONN_BASE   5'h0c
`define UCMP_IDX_DISC_BASE   5'h0f
`define UCMP_IDX_STATUS      5'h12
`define UCMP_NUM_RW_REGS     19

// field offsets inside a channel block
`define UCMP_CH_SRC          5'h00
`define UCMP_CH_METHOD       5'h01
`define UCMP_CH_DEAD         5'h02
`define UCMP_CH_LOW          5'h03
`define UCMP_CH_HIGH         5'h04

`define UCMP_REG_RESET       16'h0000
`define UCMP_SRC_MAX         6'h31
`define UCMP_METHOD_MAX      16'h000e

// status word layout
`define UCMP_ST_USER_LSB     0
`define UCMP_ST_LOGIC_LSB    2
`define UCMP_ST_DRIVE_LSB    5

// delay unit 0.1 s, at 100 ns per clock
`define UCMP_DELAY_UNIT_NS   100000000
`define UCMP_CLK_PERIOD_NS   100
`define UCMP_TICK_CYCLES     (`UCMP_DELAY_UNIT_NS / `UCMP_CLK_PERIOD_NS)

`endif

// ===== src/ucmp_pkg.sv
package ucmp_pkg;

    typedef logic [15:0] ucmp_word_t;

    typedef enum logic [2:0] {
        UCMP_MODE_EQ,
        UCMP_MODE_GE,
        UCMP_MODE_LE,
        UCMP_MODE_RANGE,
        UCMP_MODE_MATCH,
        UCMP_MODE_NONE
    } ucmp_mode_e;

endpackage : ucmp_pkg

// ===== src/ucmp_top.sv
`include "ucmp_defines.svh"

module ucmp_top #(
    parameter int NUM_SRC    = 50,
    parameter int TICK_CYCLES = `UCMP_TICK_CYCLES
) (
    input  wire logic                  sys_clk,         // 10 MHz system clock
    input  wire logic                  rst_n,           // async reset, active low
    input  wire logic                  psel,            // apb select
    input  wire logic                  penable,         // apb access phase
    input  wire logic                  pwrite,          // apb direction
    input  wire logic [7:0]            paddr,           // apb byte address
    input  wire logic [31:0]           pwdata,          // apb write data
    output logic      [31:0]           prdata,          // apb read data
    output logic                       pready,          // apb ready
    output logic                       pslverr,         // apb error
    input  wire logic [NUM_SRC*16-1:0] monitor_values,  // monitored quantities, 16 bits each
    input  wire logic [2:0]            term_logic,      // logical state per terminal
    output logic      [2:0]            term_drive,      // contact drive, 1 closes
    output logic      [1:0]            user_out,        // user-defined outputs 1 and 2
    output logic      [15:0]           timer_preset     // timer preset in 0.01 s
);

    // reset release
    logic                rst_s1_q;
    logic                rst_s2_q;
    wire logic           rst_sync_n;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_sync_n = rst_s2_q;

    // ------------------------------------------------------------------
    function automatic logic dec_digit_set(input logic [15:0] v, input int pos);
        int unsigned d;
        d = 32'(v);
        for (int i = 0; i < pos; i++) begin
            d = d / 10;
        end
        return (d % 10) == 1;
    endfunction : dec_digit_set

    function automatic ucmp_pkg::ucmp_mode_e method_mode(input logic [15:0] m);
        int unsigned ones;
        ones = m % 10;
        case (ones)
            0:       return ucmp_pkg::UCMP_MODE_EQ;
            1:       return ucmp_pkg::UCMP_MODE_GE;
            2:       return ucmp_pkg::UCMP_MODE_LE;
            3:       return ucmp_pkg::UCMP_MODE_RANGE;
            4:       return ucmp_pkg::UCMP_MODE_MATCH;
            default: return ucmp_pkg::UCMP_MODE_NONE;
        endcase
    endfunction : method_mode

    function automatic logic [15:0] pick_source(input logic [NUM_SRC*16-1:0] vals,
                                                input logic [15:0]          sel);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (sel == 16'(i)) begin
                r = vals[i*16 +: 16];
            end
        end
        return r;
    endfunction : pick_source

    // ------------------------------------------------------------------
    // register file
    ucmp_pkg::ucmp_word_t regs_q [0:`UCMP_NUM_RW_REGS-1];
    logic                 pready_q;
    logic [31:0]          prdata_q;
    logic                 pslverr_q;

    wire logic [5:0]  reg_idx   = paddr[7:2];
    wire logic        idx_rw    = reg_idx < 6'(`UCMP_IDX_STATUS);
    wire logic        idx_st    = reg_idx == 6'(`UCMP_IDX_STATUS);
    wire logic        acc_phase = psel & penable;
    wire logic        acc_bad   = ~(idx_rw | (idx_st & ~pwrite));
    wire logic        wr_commit = acc_phase & pready_q & pwrite & idx_rw;
    wire logic [4:0]  wr_idx    = reg_idx[4:0];
    wire logic [15:0] status_w;
    wire logic [31:0] rd_word   = idx_rw ? {16'h0000, regs_q[wr_idx]} :
                                  idx_st ? {16'h0000, status_w} : 32'h0000_0000;

    // one wait state: ready rises in the second access cycle
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= acc_phase & ~pready_q;
            prdata_q  <= (acc_phase & ~pready_q & ~pwrite) ? rd_word : 32'h0000_0000;
            pslverr_q <= acc_phase & ~pready_q & acc_bad;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            for (int i = 0; i < `UCMP_NUM_RW_REGS; i++) begin
                regs_q[i] <= `UCMP_REG_RESET;
            end
        end else if (wr_commit) begin
            regs_q[wr_idx] <= pwdata[15:0];
        end
    end

    assign pready       = pready_q;
    assign prdata       = prdata_q;
    assign pslverr      = pslverr_q;
    assign timer_preset = regs_q[`UCMP_IDX_TIMER];

    // ------------------------------------------------------------------
    // user-defined comparator channels
    logic [1:0] hyst_q;
    logic [1:0] user_q;

    for (genvar c = 0; c < 2; c++) begin : g_chan
        localparam logic [4:0] BASE = (c == 0) ? `UCMP_IDX_CH1_BASE : `UCMP_IDX_CH2_BASE;
        wire logic [15:0] src_sel = regs_q[BASE + `UCMP_CH_SRC];
        wire logic [15:0] method  = regs_q[BASE + `UCMP_CH_METHOD];
        wire logic [15:0] dead    = regs_q[BASE + `UCMP_CH_DEAD];
        wire logic [15:0] low_v   = regs_q[BASE + `UCMP_CH_LOW];
        wire logic [15:0] high_v  = regs_q[BASE + `UCMP_CH_HIGH];

        // out-of-range selector reads zero
        wire logic [15:0] cmp_var = pick_source(monitor_values, src_sel);
        wire ucmp_pkg::ucmp_mode_e mode = method_mode(method);
        wire logic        true_sense = dec_digit_set(method, 1);

        // widened so that low - dead below zero never wraps
        wire logic signed [17:0] var_s  = $signed({2'b00, cmp_var});
        wire logic signed [17:0] band_hi = $signed({2'b00, low_v}) + $signed({2'b00, dead});
        wire logic signed [17:0] band_lo = $signed({2'b00, low_v}) - $signed({2'b00, dead});
        wire logic        at_hi  = var_s >= band_hi;
        wire logic        at_lo  = var_s <= band_lo;
        wire logic        in_rng = (cmp_var > low_v) & (cmp_var <= high_v);
        wire logic        is_eq  = (cmp_var == low_v) | (cmp_var == high_v);
        logic             cond_d;

        always_comb begin
            case (mode)
                ucmp_pkg::UCMP_MODE_EQ:    cond_d = cmp_var == low_v;
                ucmp_pkg::UCMP_MODE_GE:    cond_d = at_hi ? 1'b1 : (at_lo ? 1'b0 : hyst_q[c]);
                ucmp_pkg::UCMP_MODE_LE:    cond_d = at_lo ? 1'b1 : (at_hi ? 1'b0 : hyst_q[c]);
                ucmp_pkg::UCMP_MODE_RANGE: cond_d = in_rng;
                ucmp_pkg::UCMP_MODE_MATCH: cond_d = is_eq;
                default:                   cond_d = 1'b0;
            endcase
        end

        always_ff @(posedge sys_clk or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
                hyst_q[c] <= 1'b0;
                user_q[c] <= 1'b0;
            end else begin
                hyst_q[c] <= cond_d;
                user_q[c] <= true_sense ? cond_d : ~cond_d;
            end
        end
    end

    assign user_out = user_q;

    // ------------------------------------------------------------------
    // 0.1 s tick for the terminal delays; free-running, so a delay
    // may end up to one tick early
    localparam int TICK_W = $clog2(TICK_CYCLES + 1);
    logic [TICK_W-1:0] tick_cnt_q;
    logic              tick_q;
    wire logic         tick_wrap = tick_cnt_q == TICK_W'(TICK_CYCLES - 1);

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
        end else begin
            tick_cnt_q <= tick_wrap ? '0 : tick_cnt_q + TICK_W'(1);
            tick_q     <= tick_wrap;
        end
    end

    // ------------------------------------------------------------------
    // output terminals: delay, then polarity
    logic [2:0] applied_q;
    logic [2:0] drive_q;
    wire logic [15:0] pol_reg = regs_q[`UCMP_IDX_POLARITY];

    for (genvar t = 0; t < 3; t++) begin : g_term
        logic [15:0] dly_cnt_q;
        wire logic        neg_logic = dec_digit_set(pol_reg, t);
        wire logic [15:0] dly_set   = term_logic[t] ? regs_q[`UCMP_IDX_CONN_BASE + 5'(t)]
                                                    : regs_q[`UCMP_IDX_DISC_BASE + 5'(t)];
        wire logic        differs   = term_logic[t] != applied_q[t];
        wire logic        expired   = dly_cnt_q >= dly_set;

        always_ff @(posedge sys_clk or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
                dly_cnt_q    <= 16'h0000;
                applied_q[t] <= 1'b0;
            end else if (!differs) begin
                dly_cnt_q    <= 16'h0000;
            end else if (expired) begin
                applied_q[t] <= term_logic[t];
                dly_cnt_q    <= 16'h0000;
            end else if (tick_q) begin
                dly_cnt_q    <= dly_cnt_q + 16'h0001;
            end
        end

        always_ff @(posedge sys_clk or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
                drive_q[t] <= 1'b0;
            end else begin
                drive_q[t] <= applied_q[t] ^ neg_logic;
            end
        end
    end

    assign term_drive = drive_q;

    assign status_w = 16'({drive_q, applied_q, user_q});

endmodule : ucmp_top
